// ---- core/ate_encoder_top.sv ----
// Audio time-slot encoder: source, gain, tone, meters and coders
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
module ate_encoder_top
  import ate_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic anaValid,
  input wire logic [19:0] anaLeft,
  input wire logic [19:0] anaRight,
  input wire logic aesValid,
  input wire logic [19:0] aesLeft,
  input wire logic [19:0] aesRight,
  input wire logic lineBitStrobe,
  output logic outValid,
  output logic [23:0] outWord,
  output logic outRight,
  output logic [4:0] outLen,
  output logic lineVariantT1,
  output logic [4:0] slotCount,
  output logic sourceSelectIndicator,
  output logic [1:0] levelLeft,
  output logic [1:0] levelRight
);
  // ----------------------------------------------------------------
  // Registers and APB slave
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg, gain_reg, group_reg, prdata_reg;
  logic [31:0] readNext;
  logic addrHit;
  logic [31:0] statusWord;
  ate_mode_t mode;
  logic compActive;
  logic [2:0] leftGroup, rightGroup, stepCount;
  logic sampleStrobe_reg;
  logic [5:0] sampleCnt_reg;
  logic [7:0] blockCnt_reg;
  logic [4:0] slotCount_reg;
  ate_level_t level_reg [2];
  wire logic apbWrite = psel && penable && pwrite;

  always_comb begin
    addrHit = 1'b1;
    readNext = 32'h00000000;
    if (paddr == ADDR_CTRL) begin
      readNext = ctrl_reg;
    end else if (paddr == ADDR_GAIN) begin
      readNext = gain_reg;
    end else if (paddr == ADDR_GROUP) begin
      readNext = group_reg;
    end else if (paddr == ADDR_STATUS) begin
      readNext = statusWord;
    end else begin
      addrHit = 1'b0;
    end
  end

  always_comb begin
    statusWord = 32'h00000000;
    statusWord[STAT_LVL_L +: 2] = level_reg[0];
    statusWord[STAT_LVL_R +: 2] = level_reg[1];
    statusWord[STAT_ANALOG] = !ctrl_reg[CTRL_AES];
    statusWord[STAT_SLOTS +: 5] = slotCount_reg;
    statusWord[STAT_COMP] = compActive;
    statusWord[STAT_BLOCK +: 8] = blockCnt_reg;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= CTRL_RESET;
      gain_reg <= GAIN_RESET;
      group_reg <= GROUP_RESET;
    end else if (apbWrite) begin
      if (paddr == ADDR_CTRL) begin
        ctrl_reg <= {18'h00000, pwdata[CTRL_W-1:0]};
      end else if (paddr == ADDR_GAIN) begin
        gain_reg <= {24'h000000, pwdata[7:0]};
      end else if (paddr == ADDR_GROUP) begin
        group_reg <= {25'h0000000, pwdata[6:0]};
      end
    end
  end

  // Read data captured in the setup phase so it is stable in access
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata_reg <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata_reg <= readNext;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrHit;

  // ----------------------------------------------------------------
  // Mode decode and J.41 skew selection
  // ----------------------------------------------------------------
  always_comb begin
    case (ctrl_reg[CTRL_MODE +: 3])
      MODE_J42: mode = MODE_J42;
      MODE_J57: mode = MODE_J57;
      default: mode = MODE_J41;
    endcase
  end

  assign leftGroup = group_reg[2:0];
  assign rightGroup = group_reg[GROUP_R +: 3];
  // Same or earlier right group falls back to no skew at all
  assign compActive = mode == MODE_J41 && ctrl_reg[CTRL_COMP]
    && rightGroup > leftGroup && rightGroup <= GROUP_LAST;
  assign stepCount = compActive ? 3'(rightGroup - leftGroup) : 3'd0;
  assign lineVariantT1 = ctrl_reg[CTRL_T1];
  assign sourceSelectIndicator = !ctrl_reg[CTRL_AES];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      slotCount_reg <= J41_SLOTS;
    end else if (mode == MODE_J57) begin
      slotCount_reg <= ctrl_reg[CTRL_H12] ? H12_SLOTS : H11_SLOTS;
    end else if (mode == MODE_J42) begin
      slotCount_reg <= ctrl_reg[CTRL_STEREO] ? J42_STEREO_SLOTS
        : J42_MONO_SLOTS;
    end else begin
      slotCount_reg <= J41_SLOTS;
    end
  end
  assign slotCount = slotCount_reg;

  // ----------------------------------------------------------------
  // Source, tone and block counters
  // ----------------------------------------------------------------
  wire logic sampleValid = ctrl_reg[CTRL_AES] ? aesValid : anaValid;
  logic [15:0] tonePhase_reg;
  wire logic [14:0] triT = tonePhase_reg[15] ? ~tonePhase_reg[14:0]
    : tonePhase_reg[14:0];
  wire logic signed [16:0] triS = $signed({1'b0, triT, 1'b0}) - 17'sd32768;
  wire logic signed [36:0] toneProd = triS * $signed({1'b0, TONE_PEAK});
  wire logic [19:0] toneSample = toneProd[34:15];
  wire logic blockEnd = sampleStrobe_reg
    && sampleCnt_reg == 6'(BLOCK_SAMPLES - 1);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tonePhase_reg <= 16'h0000;
    end else if (sampleValid) begin
      tonePhase_reg <= tonePhase_reg + TONE_PHASE_INC;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sampleStrobe_reg <= 1'b0;
    end else begin
      sampleStrobe_reg <= sampleValid;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sampleCnt_reg <= 6'd0;
      blockCnt_reg <= 8'd0;
    end else if (blockEnd) begin
      sampleCnt_reg <= 6'd0;
      blockCnt_reg <= (blockCnt_reg == 8'(MFA_BLOCKS - 1)) ? 8'd0
        : blockCnt_reg + 8'd1;
    end else if (sampleStrobe_reg) begin
      sampleCnt_reg <= sampleCnt_reg + 6'd1;
    end
  end

  // Alignment byte per block, 8 bits x 192 blocks; FSD toggles per block
  wire logic [7:0] mfaByte = (blockCnt_reg == 8'd0) ? MFA_SYNC : 8'h00;
  wire logic fsdBit = blockCnt_reg[0];

  // ----------------------------------------------------------------
  // Coding helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] alaw11(input logic [13:0] s);
    logic [12:0] m;
    logic [2:0] seg;
    logic [6:0] man;
    m = s[13] ? ~s[12:0] : s[12:0];
    seg = 3'd0;
    for (int i = 7; i < 13; i++) begin
      if (m[i]) begin
        seg = 3'(i - 6);
      end
    end
    man = (seg == 3'd0) ? m[6:0] : 7'(m >> (seg - 3'd1));
    return {s[13], seg, man};
  endfunction

  // Headroom of a block peak picks one of eight shift ranges
  function automatic logic [2:0] headroom(input logic [18:0] pk);
    logic [2:0] h;
    h = 3'd7;
    for (int i = 6; i >= 0; i--) begin
      if (pk[18-i]) begin
        h = 3'(i);
      end
    end
    return h;
  endfunction

  function automatic logic [19:0] sat20(input logic signed [36:0] v);
    if (v > 37'sd524287) begin
      return 20'h7ffff;
    end
    if (v < -37'sd524288) begin
      return 20'h80000;
    end
    return v[19:0];
  endfunction

  // ----------------------------------------------------------------
  // Per-channel path
  // ----------------------------------------------------------------
  logic [19:0] sample_reg [2];
  logic [23:0] chWord [2];
  logic [1:0] chValid;
  wire logic [19:0] rawIn [2] = '{
    ctrl_reg[CTRL_AES] ? aesLeft : anaLeft,
    ctrl_reg[CTRL_AES] ? aesRight : anaRight};
  wire logic [4:0] wordLen = (mode != MODE_J57) ? J4X_WORD_W
    : ctrl_reg[CTRL_H12] ? H12_W : H11_W;

  for (genvar ch = 0; ch < 2; ch++) begin : gChan
    wire logic signed [3:0] gs = $signed(gain_reg[ch*GAIN_R +: 4]);
    wire logic [3:0] gIdx = (gs > 4'sd6) ? 4'd12 : (gs < -4'sd6) ? 4'd0
      : 4'(gs + 4'sd6);
    wire logic signed [36:0] prod = $signed(rawIn[ch])
      * $signed({1'b0, GAIN_COEF[gIdx]});
    wire logic toneOn = ctrl_reg[CTRL_TONE + ch];
    wire logic [18:0] mag = sample_reg[ch][19] ? ~sample_reg[ch][18:0]
      : sample_reg[ch][18:0];
    logic [18:0] peak_reg;
    logic [2:0] range_reg;
    logic half_reg;
    logic [11:0] first_reg;
    wire logic [18:0] blkPeak = (mag > peak_reg) ? mag : peak_reg;
    wire logic [10:0] aCode = alaw11(sample_reg[ch][19:6]);
    wire logic aPar = (mode == MODE_J42) ? ^aCode[10:11-J42_PAR_BITS]
      : ^aCode[10:11-J41_PAR_BITS];
    wire logic [19:0] shifted = sample_reg[ch] << range_reg;
    wire logic [15:0] sigWord = {range_reg, mfaByte, fsdBit,
      ctrl_reg[CTRL_CHSTAT], ctrl_reg[CTRL_ADDDAT], 2'b00};
    wire logic sigBit = (sampleCnt_reg < 6'd16)
      && sigWord[4'd15 - sampleCnt_reg[3:0]];
    wire logic jPar = ^shifted[19:5] ^ sigBit;
    wire logic chanOn = (ch == 0) || mode != MODE_J42
      || ctrl_reg[CTRL_STEREO];

    // Tone takes the gain stage's place rather than passing through it
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        sample_reg[ch] <= 20'h00000;
      end else if (sampleValid) begin
        sample_reg[ch] <= toneOn ? toneSample
          : sat20(prod >>> 14);
      end
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        peak_reg <= 19'h00000;
        range_reg <= 3'd0;
        level_reg[ch] <= LVL_OFF;
      end else if (blockEnd) begin
        peak_reg <= 19'h00000;
        range_reg <= headroom(blkPeak);
        if (blkPeak < LVL_OFF_MAX) begin
          level_reg[ch] <= LVL_OFF;
        end else if (blkPeak < LVL_GREEN_MAX) begin
          level_reg[ch] <= LVL_GREEN;
        end else if (blkPeak <= LVL_ORANGE_MAX) begin
          level_reg[ch] <= LVL_ORANGE;
        end else begin
          level_reg[ch] <= LVL_RED;
        end
      end else if (sampleStrobe_reg) begin
        peak_reg <= blkPeak;
      end
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        half_reg <= 1'b0;
        first_reg <= 12'h000;
      end else if (sampleStrobe_reg) begin
        half_reg <= !half_reg;
        first_reg <= {aCode, aPar};
      end
    end

    assign chValid[ch] = sampleStrobe_reg && chanOn
      && (mode == MODE_J57 || half_reg);
    assign chWord[ch] = (mode != MODE_J57) ? {first_reg, aCode, aPar}
      : ctrl_reg[CTRL_H12] ? {4'h0, shifted[19:5], jPar, shifted[4:2],
      ctrl_reg[CTRL_USER]} : {8'h00, shifted[19:5], jPar};
  end

  assign levelLeft = level_reg[0];
  assign levelRight = level_reg[1];

  // ----------------------------------------------------------------
  // Right-channel skew and output merge
  // ----------------------------------------------------------------
  logic skewValid;
  logic [23:0] skewWord;
  logic rPend_reg;
  logic [23:0] rWord_reg;
  logic outValid_reg, outRight_reg;
  logic [23:0] outWord_reg;
  logic [4:0] outLen_reg;

  ate_skew_delay uSkew (
    .clk(clk),
    .reset(reset),
    .lineBitStrobe(lineBitStrobe),
    .stepCount(stepCount),
    .inValid(chValid[1]),
    .inWord(chWord[1]),
    .outValid(skewValid),
    .outWord(skewWord)
  );

  // A right word arriving as the previous one leaves stays pending
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rPend_reg <= 1'b0;
      rWord_reg <= 24'h000000;
    end else if (skewValid) begin
      rPend_reg <= 1'b1;
      rWord_reg <= skewWord;
    end else if (!chValid[0]) begin
      rPend_reg <= 1'b0;
    end
  end

  // Left has priority; right follows in the next free cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      outValid_reg <= 1'b0;
      outRight_reg <= 1'b0;
      outWord_reg <= 24'h000000;
      outLen_reg <= 5'd0;
    end else begin
      outValid_reg <= chValid[0] || rPend_reg;
      outRight_reg <= !chValid[0];
      outLen_reg <= wordLen;
      if (chValid[0] || rPend_reg) begin
        outWord_reg <= chValid[0] ? chWord[0] : rWord_reg;
      end
    end
  end

  assign outValid = outValid_reg;
  assign outRight = outRight_reg;
  assign outWord = outWord_reg;
  assign outLen = outLen_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence sBlockLast;
    sampleStrobe_reg && sampleCnt_reg == 6'd47;
  endsequence
  sequence sBlockFirst;
    sampleCnt_reg == 6'd0;
  endsequence

  AST_BLOCK_WRAP: assert property (sBlockLast |=> sBlockFirst)
    else $error("Block did not restart after 48 samples");
  AST_MFA_RANGE: assert property (blockCnt_reg < 8'd192)
    else $error("Alignment block count passed 191");
  AST_SRC_STROBE: assert property (
    anaValid && !ctrl_reg[CTRL_AES] |=> sampleStrobe_reg)
    else $error("Analog sample not taken when analog selected");
  AST_SRC_REFUSE: assert property (
    !anaValid && !ctrl_reg[CTRL_AES] |=> !sampleStrobe_reg)
    else $error("Sample taken from the unselected source");
  AST_J4X_LEN: assert property (
    outValid && $past(mode) != MODE_J57 |-> outLen == 5'd24)
    else $error("J.4x word not 24 bits");
  AST_J57_LEN: assert property ($past(mode) == MODE_J57 && outValid
    |-> outLen == ($past(ctrl_reg[CTRL_H12]) ? 5'd20 : 5'd16))
    else $error("J.57 word length wrong");
  AST_SLOTS: assert property (mode == MODE_J57 && ctrl_reg[CTRL_H12]
    |=> slotCount == 5'd30)
    else $error("H12 slot count not 30");
  AST_TONE_BYPASS: assert property (
    sampleValid && ctrl_reg[CTRL_TONE] |=> sample_reg[0] == $past(toneSample))
    else $error("Tone altered by gain stage");
  AST_GAIN_UNITY: assert property (sampleValid && !ctrl_reg[CTRL_TONE]
    && gain_reg[3:0] == 4'h0 |=> sample_reg[0] == $past(rawIn[0]))
    else $error("Unity gain changed the sample");
  AST_MONO: assert property (outValid |-> !outRight
    || !($past(mode) == MODE_J42 && !$past(ctrl_reg[CTRL_STEREO], 2)))
    else $error("Right word sent in J.42 mono");
endmodule
`default_nettype wire

// ---- core/ate_pkg.sv ----
// Constants and types shared by the audio time-slot encoder
package ate_pkg;
  // --------------------------------------------------------------
  // Register map and fields
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GAIN = 8'h04;
  localparam logic [7:0] ADDR_GROUP = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam int CTRL_MODE = 0;
  localparam int CTRL_T1 = 3;
  localparam int CTRL_STEREO = 4;
  localparam int CTRL_EMPH = 5;
  localparam int CTRL_COMP = 6;
  localparam int CTRL_H12 = 7;
  localparam int CTRL_AES = 8;
  localparam int CTRL_TONE = 9;
  localparam int CTRL_USER = 11;
  localparam int CTRL_CHSTAT = 12;
  localparam int CTRL_ADDDAT = 13;
  localparam int CTRL_W = 14;
  localparam int GAIN_R = 4;
  localparam int GROUP_R = 4;
  localparam int STAT_LVL_L = 0;
  localparam int STAT_LVL_R = 2;
  localparam int STAT_ANALOG = 4;
  localparam int STAT_SLOTS = 5;
  localparam int STAT_COMP = 10;
  localparam int STAT_BLOCK = 11;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] GAIN_RESET = 32'h0000_0000;
  localparam logic [31:0] GROUP_RESET = 32'h0000_0000;
  // --------------------------------------------------------------
  // Coding modes and meter states
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_J41 = 3'b001,
    MODE_J42 = 3'b010,
    MODE_J57 = 3'b100
  } ate_mode_t;
  typedef enum logic [1:0] {
    LVL_OFF = 2'h0,
    LVL_GREEN = 2'h1,
    LVL_ORANGE = 2'h2,
    LVL_RED = 2'h3
  } ate_level_t;
  // --------------------------------------------------------------
  // Coding and timing figures
  // --------------------------------------------------------------
  localparam int J42_PAR_BITS = 7;
  localparam int J41_PAR_BITS = 5;
  localparam logic [4:0] J4X_WORD_W = 5'd24;
  localparam logic [4:0] H11_W = 5'd16;
  localparam logic [4:0] H12_W = 5'd20;
  localparam int BLOCK_SAMPLES = 48;
  localparam int MFA_BLOCKS = 192;
  localparam logic [7:0] MFA_SYNC = 8'h1b;
  localparam logic [4:0] H11_SLOTS = 5'd24;
  localparam logic [4:0] H12_SLOTS = 5'd30;
  localparam logic [4:0] J41_SLOTS = 5'd12;
  localparam logic [4:0] J42_MONO_SLOTS = 5'd3;
  localparam logic [4:0] J42_STEREO_SLOTS = 5'd6;
  localparam logic [2:0] GROUP_LAST = 3'd4;
  localparam longint COMP_STEP_PS = 11720000;
  localparam longint E1_BIT_PS = 488281;
  localparam logic [6:0] COMP_STEP_BITS = 7'(COMP_STEP_PS / E1_BIT_PS);
  localparam logic [15:0] TONE_PHASE_INC = 16'h055b;
  localparam logic [18:0] TONE_PEAK = 19'h20276;
  localparam logic [18:0] LVL_OFF_MAX = 19'h00042;
  localparam logic [18:0] LVL_GREEN_MAX = 19'h2d6a4;
  localparam logic [18:0] LVL_ORANGE_MAX = 19'h55810;
  // Q2.14 factors for -6 dB .. +6 dB in 1 dB steps
  localparam logic [15:0] GAIN_COEF [13] = '{
    16'h2013, 16'h23f6, 16'h2862, 16'h2d4f, 16'h32d6, 16'h390a,
    16'h4000, 16'h47cf, 16'h5092, 16'h5a67, 16'h656f, 16'h71cf,
    16'h7fb2};
endpackage

// ---- core/ate_skew_delay.sv ----
// Right-channel skew delay counted in E1 bit periods
`timescale 1ns/10ps
`default_nettype none
module ate_skew_delay
  import ate_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic lineBitStrobe,
  input wire logic [2:0] stepCount,
  input wire logic inValid,
  input wire logic [23:0] inWord,
  output logic outValid,
  output logic [23:0] outWord
);
  logic busy_reg;
  logic [6:0] cnt_reg;
  logic [6:0] target_reg;
  logic outValid_reg;
  logic [23:0] word_reg;
  wire logic fire = busy_reg && cnt_reg == target_reg;

  // One word in flight is enough: codes arrive far slower than the skew
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_reg <= 1'b0;
      cnt_reg <= 7'd0;
      target_reg <= 7'd0;
      word_reg <= 24'h000000;
    end else if (inValid) begin
      busy_reg <= 1'b1;
      cnt_reg <= 7'd0;
      target_reg <= 7'(stepCount * COMP_STEP_BITS);
      word_reg <= inWord;
    end else if (fire) begin
      busy_reg <= 1'b0;
    end else if (busy_reg && lineBitStrobe) begin
      cnt_reg <= cnt_reg + 7'd1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      outValid_reg <= 1'b0;
    end else begin
      outValid_reg <= fire;
    end
  end

  assign outValid = outValid_reg;
  assign outWord = word_reg;

  AST_SKEW_COUNT: assert property (@(posedge clk) disable iff (reset)
    outValid |-> $past(cnt_reg) == $past(target_reg))
    else $error("Skew word left before its bit count");
  AST_SKEW_ZERO: assert property (@(posedge clk) disable iff (reset)
    inValid && stepCount == 3'd0 |-> ##2 outValid)
    else $error("Unskewed word not passed in two cycles");
endmodule
`default_nettype wire

// ---- test/ate_mux_model.sv ----
// Multiplexer-side model: line bit strobe and capture of coded words
`timescale 1ns/10ps
`default_nettype none
module ate_mux_model #(
  parameter int DIV = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic outValid,
  input wire logic outRight,
  input wire logic [4:0] outLen,
  input wire logic [23:0] outWord,
  output logic lineBitStrobe,
  output logic [15:0] leftAt,
  output logic [15:0] rightAt,
  output logic [15:0] rightCount,
  output logic [4:0] lastLen,
  output logic [23:0] lastWord
);
  logic [7:0] divCount;
  logic [15:0] bitCount;
  // A real line bit lasts about 122 clocks; a short DIV keeps runs brief
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      divCount <= 8'h00;
      lineBitStrobe <= 1'b0;
      bitCount <= 16'h0000;
    end else begin
      divCount <= (divCount == 8'(DIV - 1)) ? 8'h00 : divCount + 8'h01;
      lineBitStrobe <= (divCount == 8'(DIV - 1));
      if (lineBitStrobe) begin
        bitCount <= bitCount + 16'h0001;
      end
    end
  end
  // Words are stamped with the line bit count at arrival
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      leftAt <= 16'h0000;
      rightAt <= 16'h0000;
      rightCount <= 16'h0000;
      lastLen <= 5'h00;
      lastWord <= 24'h000000;
    end else if (outValid) begin
      lastLen <= outLen;
      lastWord <= outWord;
      if (outRight) begin
        rightAt <= bitCount;
        rightCount <= rightCount + 16'h0001;
      end else begin
        leftAt <= bitCount;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/ate_encoder_top_tb.sv ----
// Testbench for the audio time-slot encoder
`timescale 1ns/10ps
`default_nettype none
module ate_encoder_top_tb;
  import ate_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sampleValid = 1'b0;
  logic aesOnly = 1'b0;
  logic [19:0] anaData = 20'h0;
  logic [19:0] aesData = 20'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, lineBitStrobe, outValid, outRight;
  logic lineVariantT1, sourceSelectIndicator;
  logic [23:0] outWord, lastWord;
  logic [4:0] outLen, slotCount, lastLen;
  logic [1:0] levelLeft, levelRight;
  logic [15:0] leftAt, rightAt, rightCount, seen, gap;
  int badCount = 0;
  int numChecks = 0;
  logic [31:0] rstVal [3] = '{CTRL_RESET, GAIN_RESET, GROUP_RESET};
  logic [31:0] mCtrl [5] = '{32'h001, 32'h00a, 32'h012, 32'h104, 32'h084};
  logic [31:0] mSlot [5] = '{32'd12, 32'd3, 32'd6, 32'd24, 32'd30};
  logic [31:0] mLen [5] = '{32'd24, 32'd24, 32'd24, 32'd16, 32'd20};
  logic [31:0] lCtrl [6] = '{32'h004, 32'h104, 32'h004, 32'h004, 32'h604,
    32'h604};
  logic [7:0] lGain [6] = '{8'h00, 8'h00, 8'h00, 8'h66, 8'h66, 8'haa};
  logic [19:0] lAna [6] = '{20'h0, 20'h0, 20'h20276, 20'h20276, 20'h7ffff,
    20'h0};
  logic [1:0] lLvl [6] = '{LVL_OFF, LVL_RED, LVL_GREEN, LVL_ORANGE,
    LVL_GREEN, LVL_GREEN};
  logic [31:0] sCtrl [4] = '{32'h041, 32'h041, 32'h041, 32'h052};
  logic [7:0] sGroup [4] = '{8'h40, 8'h21, 8'h13, 8'h20};
  logic [15:0] sSteps [4] = '{16'd4, 16'd1, 16'd0, 16'd0};

  always #2 clk = ~clk;

  ate_encoder_top ate_encoder_top_i (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .anaValid(sampleValid), .anaLeft(anaData), .anaRight(anaData),
    .aesValid(sampleValid || aesOnly), .aesLeft(aesData),
    .aesRight(aesData),
    .lineBitStrobe(lineBitStrobe), .outValid(outValid), .outWord(outWord),
    .outRight(outRight), .outLen(outLen), .lineVariantT1(lineVariantT1),
    .slotCount(slotCount), .sourceSelectIndicator(sourceSelectIndicator),
    .levelLeft(levelLeft), .levelRight(levelRight));
  ate_mux_model #(.DIV(8)) ate_mux_model_i (.clk(clk), .reset(reset),
    .outValid(outValid), .outRight(outRight), .outLen(outLen),
    .outWord(outWord), .lastWord(lastWord),
    .lineBitStrobe(lineBitStrobe), .leftAt(leftAt), .rightAt(rightAt),
    .rightCount(rightCount), .lastLen(lastLen));

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      badCount++;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Both sources get a sample each time; only the selected one may count
  task smp(input logic [19:0] a, input logic [19:0] d, input int n);
    repeat (n) begin
      @(posedge clk);
      sampleValid <= 1'b1;
      anaData <= a;
      aesData <= d;
      @(posedge clk);
      sampleValid <= 1'b0;
      repeat (10) @(posedge clk);
    end
    #1;
  endtask
  task testDone;
    if (badCount == 0 && numChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    badCount++;
    testDone();
  end

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    chk("analog at reset", 32'd1, 32'(sourceSelectIndicator));
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("register reset", rstVal[i], rd);
    end
    apb(1'b1, 8'h20, 32'hffff_ffff);
    chk("unmapped write err", 32'd1, 32'(err));
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped read", 32'h0, rd);
    // ----
    // Coding modes, slot counts and word lengths
    // ----
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ADDR_CTRL, mCtrl[i]);
      smp(20'h01000, 20'h01000, 2);
      chk("slotCount", mSlot[i], 32'(slotCount));
      chk("outLen", mLen[i], 32'(lastLen));
      chk("variant", 32'(mCtrl[i][3]), 32'(lineVariantT1));
      chk("source", 32'(!mCtrl[i][8]), 32'(sourceSelectIndicator));
      // Segment 0, mantissa 0x40, parity 1 on both codes of the pair
      if (i < 3) chk("outWord", 32'h0008_1081, 32'(lastWord));
    end
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ADDR_GAIN, 32'(lGain[i]));
      apb(1'b1, ADDR_CTRL, lCtrl[i]);
      smp(lAna[i], 20'h7ffff, 100);
      chk("levelLeft", 32'(lLvl[i]), 32'(levelLeft));
      chk("levelRight", 32'(lLvl[i]), 32'(levelRight));
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status levels", 32'({lLvl[i], lLvl[i]}), 32'(rd[3:0]));
    end
    // ----
    // Skew between left and right words, in line bits
    // ----
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_GROUP, 32'(sGroup[i]));
      apb(1'b1, ADDR_CTRL, sCtrl[i]);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("compActive", 32'(sSteps[i] != 0), 32'(rd[10]));
      seen = rightCount;
      smp(20'h01000, 20'h0, 2);
      while (rightCount === seen) @(posedge clk);
      gap = rightAt - leftAt;
      chk("skew ok", 32'd1, 32'(gap >= 24 * sSteps[i] &&
        gap <= 24 * sSteps[i] + 1));
    end
    // Analog selected: a lone AES strobe must not make a word
    apb(1'b1, ADDR_CTRL, 32'h004);
    seen = rightCount;
    aesOnly <= 1'b1;
    @(posedge clk);
    aesOnly <= 1'b0;
    repeat (10) @(posedge clk);
    chk("aes refused", 32'(seen), 32'(rightCount));
    testDone();
  end
endmodule
`default_nettype wire
